// file: smc_pkg.sv
package smc_pkg;

  // register byte addresses
  localparam logic [3:0] OFS_POWER_CTRL = 4'h0;
  localparam logic [3:0] OFS_CMP_CTRL = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_FUSE_CFG = 4'hc;

  // power_ctrl_reg fields
  localparam int BIT_SLEEP_ARM = 7;
  localparam int POS_STATE_SEL_HI = 6;
  localparam int POS_STATE_SEL_LO = 4;
  localparam logic [7:0] RST_POWER_CTRL = 8'h00;

  // comparator_ctrl_status fields
  localparam int BIT_CMP_OFF = 7;
  localparam logic [7:0] RST_CMP_CTRL = 8'h00;

  // fuse/config register fields
  localparam int POS_CKSRC_HI = 3;
  localparam int POS_CKSRC_LO = 0;
  localparam int POS_SUT_HI = 5;
  localparam int POS_SUT_LO = 4;
  localparam int BIT_T2_ASYNC = 8;
  localparam logic [8:0] RST_FUSE_CFG = 9'h020;

  // power state select codes
  localparam logic [2:0] PS_IDLE = 3'h0;
  localparam logic [2:0] PS_ADC_NR = 3'h1;
  localparam logic [2:0] PS_PWR_DOWN = 3'h2;
  localparam logic [2:0] PS_PWR_SAVE = 3'h3;
  localparam logic [2:0] PS_STANDBY = 3'h6;

  // clock source fuse ranges
  localparam logic [3:0] CKSRC_EXT_CLK = 4'h0;
  localparam logic [3:0] CKSRC_INT_RC_LAST = 4'h4;
  localparam logic [3:0] CKSRC_EXT_RC_LAST = 4'h8;
  localparam logic [1:0] SUT_FAST = 2'h3;

  // wake-up timing in clock cycles of the device clock
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] CK_STARTUP_SHORT = 11'h006;
  localparam logic [CNT_W-1:0] CK_STARTUP_EXT_RC = 11'h012;
  localparam logic [CNT_W-1:0] CK_STANDBY_WAKE = 11'h006;
  localparam logic [CNT_W-1:0] CK_RUNNING_WAKE = 11'h001;
  localparam logic [CNT_W-1:0] CK_WAKE_HALT = 11'h004;
  localparam logic [CNT_W-1:0] CK_CRYSTAL_DEFAULT = 11'h400;

  // controller states
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_START = 4'h4,
    ST_HALT = 4'h8
  } smc_state_type;

endpackage

// file: smc_wake_timer.sv
`timescale 1ns/1ps
`default_nettype none

module smc_wake_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // load and count
  input wire logic load,
  input wire logic [smc_pkg::CNT_W-1:0] load_val,
  output logic done
);

  typedef struct packed {
    logic [smc_pkg::CNT_W-1:0] cnt;
  } smc_wt_type;

  smc_wt_type r_q;
  smc_wt_type r_d;

  // load n-1 so that a load of n keeps done low for exactly n-1 cycles after the load edge
  always_comb begin
    r_d = r_q;
    if (load) begin
      r_d.cnt = load_val - smc_pkg::CNT_W'(1);
    end else if (r_q.cnt != '0) begin
      r_d.cnt = r_q.cnt - smc_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign done = (r_q.cnt == '0);

endmodule

`default_nettype wire

// file: smc_ctrl.sv
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module smc_ctrl #(
  parameter logic [smc_pkg::CNT_W-1:0] CRYSTAL_STARTUP_CK = smc_pkg::CK_CRYSTAL_DEFAULT
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // avalon-mm register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // core side
  input wire logic doze_exec,
  input wire logic global_irq_en,
  input wire logic any_irq_req,
  input wire logic rst_wake_req,
  output logic core_resume,
  output logic resume_at_vector,
  output logic regfile_hold,
  // wake sources from peripherals
  input wire logic adc_enabled,
  input wire logic adc_done_irq,
  input wire logic twi_match_irq,
  input wire logic spm_ready_irq,
  input wire logic t2_ovf_flag,
  input wire logic t2_cmp_flag,
  input wire logic [1:0] timer_irq_mask,
  // external interrupt pins and their sense setup
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic [1:0] ext_irq_en,
  input wire logic [1:0] ext_irq_level_sel,
  // clock domain gates, comparator power enable and adc start pulse
  output logic cpu_clk_en,
  output logic flash_clk_en,
  output logic io_clk_en,
  output logic adc_clk_en,
  output logic async_clock_domain_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic comparator_pwr_en,
  output logic adc_start
);

  typedef struct packed {
    smc_pkg::smc_state_type state;
    logic [2:0] mode;
    logic vec;
    logic [7:0] power_ctrl_reg;
    logic [7:0] comparator_ctrl_status;
    logic [8:0] fuse_cfg;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [6:0] gates;
    logic adc_start;
    logic resume;
  } smc_ctrl_type;

  smc_ctrl_type r_q;
  smc_ctrl_type r_d;
  logic tmr_load;
  logic [smc_pkg::CNT_W-1:0] tmr_val;
  logic tmr_done;

  // startup/halt counter shared by both wake phases
  smc_wake_timer u_wake_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // decoded configuration
  logic [2:0] sel;
  logic armed;
  logic [3:0] cksrc;
  logic [1:0] startup_time_fuses;
  logic t2_async;
  logic crystal;
  logic mode_ok;
  logic doze_ok;
  logic lvl_wake;
  logic t2_wake;
  logic wake_irq;
  logic [smc_pkg::CNT_W-1:0] startup_ck;

  assign sel = r_q.power_ctrl_reg[smc_pkg::POS_STATE_SEL_HI:smc_pkg::POS_STATE_SEL_LO];
  assign armed = r_q.power_ctrl_reg[smc_pkg::BIT_SLEEP_ARM];
  assign cksrc = r_q.fuse_cfg[smc_pkg::POS_CKSRC_HI:smc_pkg::POS_CKSRC_LO];
  assign startup_time_fuses = r_q.fuse_cfg[smc_pkg::POS_SUT_HI:smc_pkg::POS_SUT_LO];
  assign t2_async = r_q.fuse_cfg[smc_pkg::BIT_T2_ASYNC];
  assign crystal = (cksrc > smc_pkg::CKSRC_EXT_RC_LAST);

  // standby without a crystal option is treated like a reserved code
  always_comb begin
    unique case (sel)
      smc_pkg::PS_IDLE, smc_pkg::PS_ADC_NR, smc_pkg::PS_PWR_DOWN, smc_pkg::PS_PWR_SAVE: mode_ok = 1'b1;
      smc_pkg::PS_STANDBY: mode_ok = crystal;
      default: mode_ok = 1'b0;
    endcase
  end

  assign doze_ok = doze_exec && armed && mode_ok;

  // only a held low level wakes from the pins; edge-sensed requests never reach here
  assign lvl_wake = |(ext_irq_en & ext_irq_level_sel & ~r_q.pin_sync);
  assign t2_wake = global_irq_en && ((t2_ovf_flag && timer_irq_mask[0]) || (t2_cmp_flag && timer_irq_mask[1]));

  // per-mode wake qualification
  always_comb begin
    unique case (r_q.mode)
      smc_pkg::PS_IDLE: wake_irq = any_irq_req || (global_irq_en && lvl_wake);
      smc_pkg::PS_ADC_NR: wake_irq = (global_irq_en && (adc_done_irq || twi_match_irq || spm_ready_irq || lvl_wake))
                                     || t2_wake;
      smc_pkg::PS_PWR_SAVE: wake_irq = (global_irq_en && (twi_match_irq || lvl_wake)) || (t2_async && t2_wake);
      default: wake_irq = global_irq_en && (twi_match_irq || lvl_wake);
    endcase
  end

  // restart time depends on clock source and startup fuses
  always_comb begin
    if (r_q.mode == smc_pkg::PS_IDLE || r_q.mode == smc_pkg::PS_ADC_NR) begin
      startup_ck = smc_pkg::CK_RUNNING_WAKE;
    end else if (r_q.mode == smc_pkg::PS_STANDBY) begin
      startup_ck = smc_pkg::CK_STANDBY_WAKE;
    end else if (cksrc <= smc_pkg::CKSRC_INT_RC_LAST) begin
      startup_ck = smc_pkg::CK_STARTUP_SHORT;
    end else if (cksrc <= smc_pkg::CKSRC_EXT_RC_LAST) begin
      startup_ck = (startup_time_fuses == smc_pkg::SUT_FAST) ? smc_pkg::CK_STARTUP_SHORT : smc_pkg::CK_STARTUP_EXT_RC;
    end else begin
      startup_ck = CRYSTAL_STARTUP_CK;
    end
  end

  // sequencer, register file and pin synchronisers
  always_comb begin
    r_d = r_q;
    tmr_load = 1'b0;
    tmr_val = smc_pkg::CK_WAKE_HALT;
    r_d.pin_meta = {ext_irq_one, ext_irq_zero};
    r_d.pin_sync = r_q.pin_meta;
    r_d.adc_start = 1'b0;
    r_d.resume = 1'b0;
    r_d.ack = (avs_read || avs_write) && !r_q.ack;
    r_d.rdata = r_q.rdata;
    if (r_d.ack) begin
      unique case (avs_address)
        smc_pkg::OFS_POWER_CTRL: r_d.rdata = {24'h000000, r_q.power_ctrl_reg};
        smc_pkg::OFS_CMP_CTRL: r_d.rdata = {24'h000000, r_q.comparator_ctrl_status};
        smc_pkg::OFS_STATUS: r_d.rdata = {17'h00000, r_q.gates, r_q.vec, r_q.mode, r_q.state};
        smc_pkg::OFS_FUSE_CFG: r_d.rdata = {23'h000000, r_q.fuse_cfg};
        default: r_d.rdata = 32'h00000000;
      endcase
    end
    // writes land on the edge where waitrequest is low
    if (avs_write && r_q.ack) begin
      if (avs_byteenable[0]) begin
        unique case (avs_address)
          smc_pkg::OFS_POWER_CTRL: r_d.power_ctrl_reg = avs_writedata[7:0];
          smc_pkg::OFS_CMP_CTRL: r_d.comparator_ctrl_status = avs_writedata[7:0];
          smc_pkg::OFS_FUSE_CFG: r_d.fuse_cfg[7:0] = avs_writedata[7:0];
          default: ;
        endcase
      end
      if (avs_byteenable[1] && avs_address == smc_pkg::OFS_FUSE_CFG) begin
        r_d.fuse_cfg[8] = avs_writedata[8];
      end
    end
    unique case (r_q.state)
      smc_pkg::ST_RUN: begin
        if (doze_ok) begin
          r_d.state = smc_pkg::ST_SLEEP;
          r_d.mode = sel;
          r_d.vec = 1'b0;
          r_d.adc_start = adc_enabled && (sel == smc_pkg::PS_IDLE || sel == smc_pkg::PS_ADC_NR);
        end
      end
      smc_pkg::ST_SLEEP: begin
        if (rst_wake_req || wake_irq) begin
          r_d.state = smc_pkg::ST_START;
          r_d.vec = rst_wake_req;
          tmr_load = 1'b1;
          tmr_val = startup_ck;
        end
      end
      smc_pkg::ST_START: begin
        if (tmr_done) begin
          if (r_q.vec) begin
            r_d.state = smc_pkg::ST_RUN;
            r_d.resume = 1'b1;
          end else begin
            r_d.state = smc_pkg::ST_HALT;
            tmr_load = 1'b1;
            tmr_val = smc_pkg::CK_WAKE_HALT;
          end
        end
      end
      smc_pkg::ST_HALT: begin
        if (tmr_done) begin
          r_d.state = smc_pkg::ST_RUN;
          r_d.resume = 1'b1;
        end
      end
    endcase
    // gates order: cpu flash io adc async osc tosc, taken from the next state
    unique case (r_d.state)
      smc_pkg::ST_RUN: r_d.gates = {6'h3f, t2_async};
      smc_pkg::ST_HALT: r_d.gates = {2'h0, 4'hf, t2_async};
      default: begin
        unique case (r_d.mode)
          smc_pkg::PS_IDLE: r_d.gates = {2'h0, 4'hf, t2_async};
          smc_pkg::PS_ADC_NR: r_d.gates = {3'h0, 3'h7, t2_async};
          smc_pkg::PS_PWR_SAVE: r_d.gates = {4'h0, t2_async, 1'b0, t2_async};
          smc_pkg::PS_STANDBY: r_d.gates = 7'h02;
          default: r_d.gates = 7'h00;
        endcase
        // oscillator restarts while the startup count runs
        if (r_d.state == smc_pkg::ST_START) begin
          r_d.gates[1] = 1'b1;
        end
      end
    endcase
  end

  // single register for all controller state except the wake timer count; async reset loads constants only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r_q.state <= smc_pkg::ST_RUN;
      r_q.mode <= smc_pkg::PS_IDLE;
      r_q.vec <= 1'b0;
      r_q.power_ctrl_reg <= smc_pkg::RST_POWER_CTRL;
      r_q.comparator_ctrl_status <= smc_pkg::RST_CMP_CTRL;
      r_q.fuse_cfg <= smc_pkg::RST_FUSE_CFG;
      r_q.ack <= 1'b0;
      r_q.rdata <= 32'h00000000;
      r_q.pin_meta <= 2'h3;
      r_q.pin_sync <= 2'h3;
      r_q.gates <= 7'h7e;
      r_q.adc_start <= 1'b0;
      r_q.resume <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs
  assign avs_readdata = r_q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !r_q.ack;
  assign cpu_clk_en = r_q.gates[6];
  assign flash_clk_en = r_q.gates[5];
  assign io_clk_en = r_q.gates[4];
  assign adc_clk_en = r_q.gates[3];
  assign async_clock_domain_en = r_q.gates[2];
  assign main_osc_en = r_q.gates[1];
  assign timer_osc_en = r_q.gates[0];
  assign comparator_pwr_en = !r_q.comparator_ctrl_status[smc_pkg::BIT_CMP_OFF];
  assign adc_start = r_q.adc_start;
  assign core_resume = r_q.resume;
  assign resume_at_vector = r_q.vec;
  // core must not write registers or SRAM while clocks are gated
  assign regfile_hold = (r_q.state != smc_pkg::ST_RUN);

  // checks
  sequence s_halt_entry;
    r_q.state == smc_pkg::ST_START && $past(r_q.state) == smc_pkg::ST_SLEEP && !r_q.vec;
  endsequence

  sequence s_four_halted;
    (!cpu_clk_en && regfile_hold) [*4];
  endsequence

  AST_NO_ARM: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.state == smc_pkg::ST_RUN && doze_exec && !armed) |=> (r_q.state == smc_pkg::ST_RUN && cpu_clk_en))
    else $error("doze without arm bit entered sleep");

  AST_RESERVED_NOP: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.state == smc_pkg::ST_RUN && doze_exec && (sel == 3'h4 || sel == 3'h5)) |=> (cpu_clk_en && io_clk_en))
    else $error("reserved code gated a clock");

  AST_HALT_FOUR: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.state == smc_pkg::ST_HALT && $past(r_q.state) == smc_pkg::ST_START) |-> s_four_halted ##1 core_resume)
    else $error("wake halt is not four cycles");

  AST_IDLE_GATES: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.state == smc_pkg::ST_SLEEP && r_q.mode == smc_pkg::PS_IDLE)
    |-> (!cpu_clk_en && !flash_clk_en && io_clk_en && adc_clk_en))
    else $error("idle gating wrong");

  AST_ADC_AUTOSTART: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.state == smc_pkg::ST_RUN && doze_ok && adc_enabled && sel == smc_pkg::PS_ADC_NR)
    |=> (adc_start && !io_clk_en))
    else $error("no conversion start on noise entry");

  AST_NOISE_GATES: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.state == smc_pkg::ST_SLEEP && r_q.mode == smc_pkg::PS_ADC_NR) |-> (!io_clk_en && adc_clk_en && !cpu_clk_en))
    else $error("noise reduction gating wrong");

  AST_DOWN_OSC: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.state == smc_pkg::ST_SLEEP && r_q.mode == smc_pkg::PS_PWR_DOWN) |-> (!main_osc_en && !async_clock_domain_en))
    else $error("oscillator runs in power-down");

  AST_EDGE_NO_WAKE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.state == smc_pkg::ST_SLEEP && r_q.mode == smc_pkg::PS_PWR_DOWN && !rst_wake_req && !twi_match_irq
    && !lvl_wake) |=> r_q.state == smc_pkg::ST_SLEEP)
    else $error("power-down left without a legal source");

  AST_STANDBY_SIX: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_halt_entry and (r_q.mode == smc_pkg::PS_STANDBY))
    |-> (r_q.state == smc_pkg::ST_START) [*6] ##1 r_q.state == smc_pkg::ST_HALT)
    else $error("standby wake not six cycles");

  // startup length is counted here, since the longest crystal count is too long for a delay range
  logic [smc_pkg::CNT_W:0] start_cnt_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      start_cnt_q <= '0;
    end else begin
      start_cnt_q <= (r_q.state == smc_pkg::ST_START) ? start_cnt_q + 1'b1 : '0;
    end
  end

  AST_RESET_VECTOR: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.state == smc_pkg::ST_START && r_q.vec && tmr_done) |=> (core_resume && resume_at_vector))
    else $error("reset wake did not resume at vector");

  AST_START_BOUND: assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.state == smc_pkg::ST_START) |-> !start_cnt_q[smc_pkg::CNT_W])
    else $error("startup phase never ends");

endmodule

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic doze_exec = 1'b0, global_irq_en = 1'b1, any_irq_req = 1'b0, rst_wake_req = 1'b0;
  logic core_resume, resume_at_vector, regfile_hold;
  logic adc_enabled = 1'b1, adc_done_irq = 1'b0, twi_match_irq = 1'b0, spm_ready_irq = 1'b0;
  logic t2_ovf_flag = 1'b0, t2_cmp_flag = 1'b0;
  logic [1:0] timer_irq_mask = 2'h0;
  logic ext_irq_zero = 1'b1, ext_irq_one = 1'b1;
  logic [1:0] ext_irq_en = 2'h0;
  logic [1:0] ext_irq_level_sel = 2'h0;
  logic cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en, async_clock_domain_en;
  logic main_osc_en, timer_osc_en, comparator_pwr_en, adc_start;
  logic [31:0] q;
  int fail_count = 0;
  int n_tests = 0;
  int n_adc = 0;

  // short crystal count keeps the run brief; only the standby scenario selects a crystal, and standby wake does not use this count
  smc_ctrl #(.CRYSTAL_STARTUP_CK(11'h008)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .doze_exec(doze_exec),
    .global_irq_en(global_irq_en), .any_irq_req(any_irq_req), .rst_wake_req(rst_wake_req),
    .core_resume(core_resume), .resume_at_vector(resume_at_vector), .regfile_hold(regfile_hold),
    .adc_enabled(adc_enabled), .adc_done_irq(adc_done_irq), .twi_match_irq(twi_match_irq),
    .spm_ready_irq(spm_ready_irq), .t2_ovf_flag(t2_ovf_flag), .t2_cmp_flag(t2_cmp_flag),
    .timer_irq_mask(timer_irq_mask), .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one),
    .ext_irq_en(ext_irq_en), .ext_irq_level_sel(ext_irq_level_sel), .cpu_clk_en(cpu_clk_en),
    .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en), .adc_clk_en(adc_clk_en),
    .async_clock_domain_en(async_clock_domain_en), .main_osc_en(main_osc_en),
    .timer_osc_en(timer_osc_en), .comparator_pwr_en(comparator_pwr_en), .adc_start(adc_start)
  );

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // adc_start is a one-cycle pulse, so count it rather than poll it
  always @(posedge sys_clk) begin
    if (adc_start === 1'b1) n_adc++;
  end

  function automatic logic [31:0] gates();
    return {25'h0, cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en, async_clock_domain_en,
            main_osc_en, timer_osc_en};
  endfunction

  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one bus cycle: hold everything until waitrequest is sampled low, then release
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      chk(0, 1, "bus timeout");
      finish_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  // arm, select and execute doze back to back, so no stray sleep can slip in
  task automatic doze(input logic arm, input logic [2:0] code);
    bus(1'b1, 4'h0, {24'h0, arm, code, 4'h0});
    doze_exec <= 1'b1;
    @(posedge sys_clk);
    doze_exec <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // caller raises the wake source at an edge just before calling
  task automatic wake(input int exp_k, input logic exp_vec, input logic [31:0] exp_g);
    int k;
    for (k = 1; k <= 2000; k++) begin
      @(posedge sys_clk);
      #1;
      if (core_resume === 1'b1) break;
    end
    if (k > 2000) begin
      chk(0, 1, "wake timeout");
      finish_test();
    end
    chk(k, exp_k, "wake latency");
    chk(resume_at_vector, exp_vec, "vector flag");
    chk(gates(), exp_g, "gates after wake");
    chk(regfile_hold, 1'b0, "hold after wake");
    @(posedge sys_clk);
  endtask

  // no wake may happen for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      chk(core_resume, 1'b0, "unexpected wake");
    end
    @(posedge sys_clk);
  endtask

  task automatic sc_reset();
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0, "power ctrl reset");
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0, "cmp ctrl reset");
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h20, "fuse reset");
    bus(1'b1, 4'h8, 32'hffff);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h7e01, "status after reset and write");
    bus(1'b1, 4'h2, 32'hff);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0, "unmapped read");
  endtask

  // unarmed, reserved codes 4 and 5 and standby without crystal all do nothing
  task automatic sc_noop();
    logic [3:0] t [4] = '{4'h0, 4'hc, 4'hd, 4'he};
    int n0;
    n0 = n_adc;
    foreach (t[i]) begin
      @(posedge sys_clk);
      doze(t[i][3], t[i][2:0]);
      chk(gates(), 32'h7e, "gates after refused doze");
      chk(regfile_hold, 1'b0, "hold after refused doze");
    end
    chk(n_adc, n0, "no conversion on refused doze");
    @(posedge sys_clk);
  endtask

  task automatic sc_idle();
    int n0;
    n0 = n_adc;
    doze(1'b1, 3'h0);
    chk(gates(), 32'h1e, "idle gates");
    chk(n_adc, n0 + 1, "idle conversion start");
    chk(regfile_hold, 1'b1, "hold in sleep");
    @(posedge sys_clk);
    bus(1'b0, 4'h8, 32'h0);
    chk(q[6:0], 7'h02, "status in idle");
    any_irq_req <= 1'b1;
    wake(6, 1'b0, 32'h7e);
    any_irq_req <= 1'b0;
  endtask

  task automatic sc_adcnr();
    int n0;
    n0 = n_adc;
    doze(1'b1, 3'h1);
    chk(gates(), 32'h0e, "noise mode gates");
    chk(n_adc, n0 + 1, "noise mode conversion start");
    @(posedge sys_clk);
    any_irq_req <= 1'b1;
    quiet(10);
    adc_done_irq <= 1'b1;
    wake(6, 1'b0, 32'h7e);
    adc_done_irq <= 1'b0;
    any_irq_req <= 1'b0;
  endtask

  // pin held low until recognised, first as edge sense, then as level sense
  task automatic sc_pdown();
    ext_irq_en <= 2'h1;
    doze(1'b1, 3'h2);
    chk(gates(), 32'h0, "power-down gates");
    @(posedge sys_clk);
    ext_irq_zero <= 1'b0;
    quiet(10);
    ext_irq_level_sel <= 2'h1;
    wake(11, 1'b0, 32'h7e);
    ext_irq_zero <= 1'b1;
    ext_irq_level_sel <= 2'h0;
  endtask

  // timer 2 wake needs its mask bit; async select is set as software should
  task automatic sc_psave();
    bus(1'b1, 4'hc, 32'h120);
    doze(1'b1, 3'h3);
    chk(gates(), 32'h05, "power-save gates");
    @(posedge sys_clk);
    t2_ovf_flag <= 1'b1;
    quiet(10);
    timer_irq_mask <= 2'h1;
    wake(11, 1'b0, 32'h7f);
    t2_ovf_flag <= 1'b0;
    doze(1'b1, 3'h3);
    @(posedge sys_clk);
    t2_cmp_flag <= 1'b1;
    quiet(10);
    timer_irq_mask <= 2'h2;
    wake(11, 1'b0, 32'h7f);
    t2_cmp_flag <= 1'b0;
    timer_irq_mask <= 2'h0;
    bus(1'b1, 4'hc, 32'h20);
  endtask

  task automatic sc_standby();
    bus(1'b1, 4'hc, 32'h29);
    doze(1'b1, 3'h6);
    chk(gates(), 32'h02, "standby gates");
    @(posedge sys_clk);
    twi_match_irq <= 1'b1;
    wake(11, 1'b0, 32'h7e);
    twi_match_irq <= 1'b0;
    bus(1'b1, 4'hc, 32'h20);
  endtask

  task automatic sc_rstwake();
    doze(1'b1, 3'h2);
    @(posedge sys_clk);
    rst_wake_req <= 1'b1;
    wake(7, 1'b1, 32'h7e);
    rst_wake_req <= 1'b0;
  endtask

  task automatic sc_cmp();
    bus(1'b1, 4'h4, 32'h80);
    #1;
    chk(comparator_pwr_en, 1'b0, "comparator off");
    @(posedge sys_clk);
    bus(1'b1, 4'h4, 32'h0);
    #1;
    chk(comparator_pwr_en, 1'b1, "comparator on");
    @(posedge sys_clk);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    sc_reset();
    sc_noop();
    sc_idle();
    sc_adcnr();
    sc_pdown();
    sc_psave();
    sc_standby();
    sc_rstwake();
    sc_cmp();
    finish_test();
  end
endmodule

`default_nettype wire
